// file: logic/mcb_pkg.sv
// mcb_pkg: constants shared by the mode control bank and its acceptance filter.
// assumes 16-bit register data and byte offsets on the module bus.
package mcb_pkg;

  // register byte offsets
  localparam logic [15:0] MCB_OFS_SET   = 16'h1032;
  localparam logic [15:0] MCB_OFS_CLEAR = 16'h1034;
  localparam logic [15:0] MCB_OFS_TADDR = 16'h1036;

  // mode bit positions, identical in set and clear registers
  localparam int MCB_B_MEM_TEST   = 0;
  localparam int MCB_B_OFFLINE    = 1;
  localparam int MCB_B_DATA_RST   = 2;
  localparam int MCB_B_OVR_DIS    = 3;
  localparam int MCB_B_ZS_DIS     = 4;
  localparam int MCB_B_VALID_DIS  = 5;
  localparam int MCB_B_ACQ_TEST   = 6;
  localparam int MCB_B_SLIDE_EN   = 7;
  localparam int MCB_B_THR_RES    = 8;
  localparam int MCB_B_STOP_MODE  = 10;
  localparam int MCB_B_AUTO_ADV   = 11;
  localparam int MCB_B_EMPTY_WR   = 12;
  localparam int MCB_B_SLIDE_SUB  = 13;
  localparam int MCB_B_CNT_SRC    = 14;

  // implemented bits; reserved positions 9 and 15 read zero
  localparam logic [15:0] MCB_MODE_MASK  = 16'h7DFF;
  // slide enable, auto advance and counter source default to one
  localparam logic [15:0] MCB_MODE_RESET = 16'h4880;
  localparam logic [15:0] MCB_ZERO16     = 16'h0000;

  // threshold scaling shifts for the rejection test
  localparam int MCB_THR_SHIFT_COARSE = 4;
  localparam int MCB_THR_SHIFT_FINE   = 1;

  // bus answer state
  typedef enum logic [0:0] {
    MCB_RD_IDLE = 1'b0,
    MCB_RD_ANS  = 1'b1
  } mcb_rd_t;

endpackage

// file: logic/mcb_mode_if.sv
// mcb_mode_if: mode bits handed from the bank to the acceptance filter.
// assumes both ends share the bank clock.
`timescale 1ns/1ns
interface mcb_mode_if;
  logic ovr_dis;
  logic zs_dis;
  logic valid_dis;
  logic thr_res;
  logic stop_mode;

  modport bank (output ovr_dis, output zs_dis, output valid_dis, output thr_res, output stop_mode);
  modport filt (input ovr_dis, input zs_dis, input valid_dis, input thr_res, input stop_mode);
endinterface

// file: logic/mcb_accept_filter.sv
// mcb_accept_filter: decides whether one converted sample may be stored.
// assumes the caller registers the answer; purely combinational here.
`timescale 1ns/1ns
module mcb_accept_filter
  import mcb_pkg::*;
#(
  parameter int VAL_W = 12,
  parameter int THR_W = 8
) (
  // mode bits
  mcb_mode_if.filt      mode,
  // sample
  input  wire logic [VAL_W-1:0] value,
  input  wire logic [THR_W-1:0] threshold,
  input  wire logic             overflow,
  input  wire logic             valid,
  // decision
  output logic                  accept
);

  // a coarse threshold must fit the value width without losing its top bits
  if (VAL_W < THR_W + MCB_THR_SHIFT_COARSE) begin : g_bad_width
    $error("value narrower than scaled threshold");
  end

  logic [VAL_W-1:0] thr_level;
  logic             ovr_ok;
  logic             thr_ok;
  logic             valid_ok;

  // threshold scaled coarse or fine before comparison
  always_comb begin
    if (mode.thr_res) begin
      thr_level = VAL_W'(threshold) << MCB_THR_SHIFT_FINE;
    end else begin
      thr_level = VAL_W'(threshold) << MCB_THR_SHIFT_COARSE;
    end
    ovr_ok   = mode.ovr_dis | ~overflow;
    thr_ok   = mode.zs_dis | (value >= thr_level);
    // validity only matters in common stop
    valid_ok = ~mode.stop_mode | mode.valid_dis | valid;
    accept   = ovr_ok & thr_ok & valid_ok;
  end

endmodule

// file: logic/mcb_mode_bank.sv
// mcb_mode_bank: set/clear mode register, test write address and the mode-driven
// controls of a multichannel converter.
// assumes single-cycle register strobes synchronous to MCLK from the bus decoder.
//
// Notes on behaviour
// - writing ones to set location sets bits
// - zeros written to set never clear bits
// - reading set location returns all mode bits
// - writing ones to clear location clears bits
// - clear uses same bit positions as set
// - memory test bit enables direct buffer writes
// - offline bit stops all conversions
// - data reset bit issues data reset
// - overflow check disable stores overflowed conversions
// - zero suppression disable stores data below threshold
// - validity check disable stores invalid common-stop data
// - acquisition test stores test FIFO data
// - slide disabled drives programmed constant value
// - threshold resolution selects times 16 or 2
// - start-stop bit selects common start or stop
// - auto advance steps read pointer on reads
// - empty event still writes header and end word
// - slide subtraction disable bypasses subtraction section
// - counter source chooses all or accepted triggers
// - write-only test write address register
// - counter source sits at bit 14
// - auto advance sits at bit 11
// - acquisition test sits at bit 6
// - memory test sits at bit 0
`timescale 1ns/1ns
module mcb_mode_bank
  import mcb_pkg::*;
#(
  parameter int TADDR_W = 11,
  parameter int SLIDE_W = 8,
  parameter int VAL_W   = 12,
  parameter int THR_W   = 8
) (
  // clock and reset
  input  wire logic               MCLK,
  input  wire logic               RSTN,
  // register port
  input  wire logic [15:0]        REG_ADDR,
  input  wire logic [15:0]        REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output logic [15:0]             REG_RDATA,
  output logic                    REG_RVALID,
  // conversion and storage controls
  output logic                    CONVERT_EN,
  output logic                    DATA_RESET,
  output logic                    MEM_TEST_EN,
  output logic [TADDR_W-1:0]      TEST_WRITE_ADDR,
  output logic                    STORE_FROM_TEST,
  output logic                    COMMON_STOP,
  output logic                    EMPTY_EVENT_WRITE,
  // sliding scale
  input  wire logic               SLIDE_STEP,
  input  wire logic [SLIDE_W-1:0] SLIDE_CONST,
  output logic [SLIDE_W-1:0]      SLIDE_DAC,
  output logic                    SLIDE_SUB_BYPASS,
  // sample acceptance
  input  wire logic               SAMPLE_STB,
  input  wire logic [VAL_W-1:0]   SAMPLE_VALUE,
  input  wire logic [THR_W-1:0]   SAMPLE_THRESHOLD,
  input  wire logic               SAMPLE_OVERFLOW,
  input  wire logic               SAMPLE_VALID,
  output logic                    SAMPLE_ACCEPT,
  // event counter and readout pointer
  input  wire logic               TRIGGER,
  input  wire logic               TRIGGER_ACCEPTED,
  output logic                    EVENT_COUNT_INC,
  input  wire logic               BUFFER_READ,
  input  wire logic               MANUAL_ADVANCE,
  output logic                    READ_POINTER_ADVANCE
);

  // widths the bus word cannot carry are refused while the design is built
  if (TADDR_W < 1 || TADDR_W > 16) begin : g_bad_taddr
    $error("test address width out of range");
  end
  if (SLIDE_W < 1 || SLIDE_W > 16) begin : g_bad_slide
    $error("slide width out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode and mode bits

  logic [15:0]        mode;
  logic [15:0]        next_mode;
  logic [TADDR_W-1:0] taddr;
  logic [TADDR_W-1:0] next_taddr;
  logic               hit_set;
  logic               hit_clear;
  logic               hit_taddr;

  // set and clear sit at distinct offsets, so they never meet in one cycle
  always_comb begin
    hit_set   = (REG_ADDR == MCB_OFS_SET);
    hit_clear = (REG_ADDR == MCB_OFS_CLEAR);
    hit_taddr = (REG_ADDR == MCB_OFS_TADDR);
    next_mode  = mode;
    next_taddr = taddr;
    if (REG_WR && hit_set) begin
      next_mode = mode | (REG_WDATA & MCB_MODE_MASK);
    end else if (REG_WR && hit_clear) begin
      next_mode = mode & ~(REG_WDATA & MCB_MODE_MASK);
    end
    if (REG_WR && hit_taddr) begin
      next_taddr = REG_WDATA[TADDR_W-1:0];
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      mode  <= MCB_MODE_RESET;
      taddr <= '0;
    end else begin
      mode  <= next_mode;
      taddr <= next_taddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read answer, one cycle after the strobe

  mcb_rd_t     rd_state;
  mcb_rd_t     next_rd_state;
  logic [15:0] next_rdata;

  // only the set location reads back; write-only and unmapped read zero
  always_comb begin
    next_rdata    = MCB_ZERO16;
    next_rd_state = MCB_RD_IDLE;
    if (REG_RD) begin
      next_rd_state = MCB_RD_ANS;
      if (hit_set) begin
        next_rdata = mode;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_state  <= MCB_RD_IDLE;
      REG_RDATA <= MCB_ZERO16;
    end else begin
      rd_state  <= next_rd_state;
      REG_RDATA <= next_rdata;
    end
  end

  always_comb begin
    unique case (rd_state)
      MCB_RD_IDLE: REG_RVALID = 1'b0;
      MCB_RD_ANS:  REG_RVALID = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // acceptance filter

  mcb_mode_if mode_bus ();
  logic       accept_now;

  assign mode_bus.ovr_dis   = mode[MCB_B_OVR_DIS];
  assign mode_bus.zs_dis    = mode[MCB_B_ZS_DIS];
  assign mode_bus.valid_dis = mode[MCB_B_VALID_DIS];
  assign mode_bus.thr_res   = mode[MCB_B_THR_RES];
  assign mode_bus.stop_mode = mode[MCB_B_STOP_MODE];

  mcb_accept_filter #(
    .VAL_W (VAL_W),
    .THR_W (THR_W)
  ) u_filter (
    .mode      (mode_bus.filt),
    .value     (SAMPLE_VALUE),
    .threshold (SAMPLE_THRESHOLD),
    .overflow  (SAMPLE_OVERFLOW),
    .valid     (SAMPLE_VALID),
    .accept    (accept_now)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode-driven controls, all registered so outputs leave from flip-flops

  logic               next_convert_en;
  logic               next_data_reset;
  logic               next_mem_test;
  logic               next_from_test;
  logic               next_common_stop;
  logic               next_empty_wr;
  logic               next_sub_bypass;
  logic               next_accept;
  logic               next_cnt_inc;
  logic               next_rp_adv;
  logic [SLIDE_W-1:0] slide_cnt;
  logic [SLIDE_W-1:0] next_slide_cnt;
  logic [SLIDE_W-1:0] next_slide_dac;

  // the outputs trail the mode bits by one cycle; a clean trade for flop outputs
  always_comb begin
    next_convert_en  = ~mode[MCB_B_OFFLINE];
    // held for as long as the bit stays set, released by the clear location
    next_data_reset  = mode[MCB_B_DATA_RST];
    next_mem_test    = mode[MCB_B_MEM_TEST];
    next_from_test   = mode[MCB_B_ACQ_TEST];
    next_common_stop = mode[MCB_B_STOP_MODE];
    next_empty_wr    = mode[MCB_B_EMPTY_WR];
    next_sub_bypass  = mode[MCB_B_SLIDE_SUB];
    next_accept      = SAMPLE_STB & accept_now;
    next_cnt_inc     = TRIGGER & (mode[MCB_B_CNT_SRC] | TRIGGER_ACCEPTED);
    next_rp_adv      = (mode[MCB_B_AUTO_ADV] & BUFFER_READ) |
                       (~mode[MCB_B_AUTO_ADV] & MANUAL_ADVANCE);
    next_slide_cnt   = slide_cnt;
    if (mode[MCB_B_SLIDE_EN] && SLIDE_STEP) begin
      next_slide_cnt = slide_cnt + 1'b1;
    end
    // disabled slide pins the converter to the programmed constant
    next_slide_dac = mode[MCB_B_SLIDE_EN] ? slide_cnt : SLIDE_CONST;
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      CONVERT_EN           <= 1'b0;
      DATA_RESET           <= 1'b0;
      MEM_TEST_EN          <= 1'b0;
      STORE_FROM_TEST      <= 1'b0;
      COMMON_STOP          <= 1'b0;
      EMPTY_EVENT_WRITE    <= 1'b0;
      SLIDE_SUB_BYPASS     <= 1'b0;
      SAMPLE_ACCEPT        <= 1'b0;
      EVENT_COUNT_INC      <= 1'b0;
      READ_POINTER_ADVANCE <= 1'b0;
      slide_cnt            <= '0;
      SLIDE_DAC            <= '0;
      TEST_WRITE_ADDR      <= '0;
    end else begin
      CONVERT_EN           <= next_convert_en;
      DATA_RESET           <= next_data_reset;
      MEM_TEST_EN          <= next_mem_test;
      STORE_FROM_TEST      <= next_from_test;
      COMMON_STOP          <= next_common_stop;
      EMPTY_EVENT_WRITE    <= next_empty_wr;
      SLIDE_SUB_BYPASS     <= next_sub_bypass;
      SAMPLE_ACCEPT        <= next_accept;
      EVENT_COUNT_INC      <= next_cnt_inc;
      READ_POINTER_ADVANCE <= next_rp_adv;
      slide_cnt            <= next_slide_cnt;
      SLIDE_DAC            <= next_slide_dac;
      TEST_WRITE_ADDR      <= next_taddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  a_set_forces_ones: assert property (
    REG_WR && REG_ADDR == MCB_OFS_SET |=> ((mode & ($past(REG_WDATA) & MCB_MODE_MASK))
                                         == ($past(REG_WDATA) & MCB_MODE_MASK)))
    else $error("set write did not force ones");

  a_set_keeps_ones: assert property (
    REG_WR && REG_ADDR == MCB_OFS_SET |=> ((mode & $past(mode)) == $past(mode)))
    else $error("set write cleared a bit");

  a_read_returns_mode: assert property (
    REG_RD && REG_ADDR == MCB_OFS_SET |=> REG_RVALID && REG_RDATA == $past(mode))
    else $error("set read returned wrong value");

  a_clear_drops_ones: assert property (
    REG_WR && REG_ADDR == MCB_OFS_CLEAR
    |=> (mode == ($past(mode) & ~($past(REG_WDATA) & MCB_MODE_MASK))))
    else $error("clear write wrong");

  a_reset_follows_bit: assert property (
    REG_WR && REG_ADDR == MCB_OFS_CLEAR && REG_WDATA[MCB_B_DATA_RST] |=> ##1 !DATA_RESET)
    else $error("data reset not released");

  a_offline_no_conv: assert property (
    mode[MCB_B_OFFLINE] |=> !CONVERT_EN)
    else $error("conversion enabled while offline");

  a_counter_source: assert property (
    TRIGGER && !TRIGGER_ACCEPTED && !mode[MCB_B_CNT_SRC] |=> !EVENT_COUNT_INC)
    else $error("unaccepted trigger counted");

  a_auto_advance: assert property (
    BUFFER_READ && mode[MCB_B_AUTO_ADV] |=> READ_POINTER_ADVANCE)
    else $error("auto advance missed");

  a_slide_const: assert property (
    !mode[MCB_B_SLIDE_EN] |=> SLIDE_DAC == $past(SLIDE_CONST))
    else $error("slide dac not constant");

  a_taddr_held: assert property (
    REG_WR && REG_ADDR == MCB_OFS_TADDR |=> TEST_WRITE_ADDR == $past(REG_WDATA[TADDR_W-1:0]))
    else $error("test address not stored");

  a_data_reset_on: assert property (
    REG_WR && REG_ADDR == MCB_OFS_SET && REG_WDATA[MCB_B_DATA_RST] |=> ##1 DATA_RESET)
    else $error("data reset not raised");

  a_mem_test_on: assert property (
    REG_WR && REG_ADDR == MCB_OFS_SET && REG_WDATA[MCB_B_MEM_TEST] |=> ##1 MEM_TEST_EN)
    else $error("memory test mode not entered");

  a_acq_test_on: assert property (
    REG_WR && REG_ADDR == MCB_OFS_SET && REG_WDATA[MCB_B_ACQ_TEST] |=> ##1 STORE_FROM_TEST)
    else $error("acquisition test not selected");

  a_stop_select_on: assert property (
    REG_WR && REG_ADDR == MCB_OFS_SET && REG_WDATA[MCB_B_STOP_MODE] |=> ##1 COMMON_STOP)
    else $error("common stop not selected");

  a_empty_write_on: assert property (
    REG_WR && REG_ADDR == MCB_OFS_SET && REG_WDATA[MCB_B_EMPTY_WR] |=> ##1 EMPTY_EVENT_WRITE)
    else $error("empty event write not enabled");

  a_sub_bypass_on: assert property (
    REG_WR && REG_ADDR == MCB_OFS_SET && REG_WDATA[MCB_B_SLIDE_SUB] |=> ##1 SLIDE_SUB_BYPASS)
    else $error("slide subtraction not bypassed");

  a_counter_source_sel_count: assert property (
    TRIGGER && mode[MCB_B_CNT_SRC] |=> EVENT_COUNT_INC)
    else $error("trigger not counted");

  a_manual_hold: assert property (
    !mode[MCB_B_AUTO_ADV] && !MANUAL_ADVANCE |=> !READ_POINTER_ADVANCE)
    else $error("read pointer moved without manual advance");

  c_set_then_clear: cover property (
    REG_WR && REG_ADDR == MCB_OFS_SET ##[1:20] REG_WR && REG_ADDR == MCB_OFS_CLEAR);
  c_data_reset: cover property (DATA_RESET ##1 !DATA_RESET);
  c_reject: cover property (SAMPLE_STB && !accept_now);
  c_manual_adv: cover property (MANUAL_ADVANCE && !mode[MCB_B_AUTO_ADV]);

endmodule

// file: verification/mcb_host_model.sv
// mcb_host_model: bus master that writes and reads the mode bank registers.
// assumes the bank samples its strobes on the rising MCLK edge.
`timescale 1ns/1ns
module mcb_host_model #(
  // arbitrary read-side test address kept apart from the write side
  parameter logic [10:0] READ_TEST_ADDR = 11'h7FF
) (
  // clock
  input  wire logic        mclk,
  // register port
  output logic [15:0]      reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  import mcb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  end

  // one write pulse; returns the word really sent
  task automatic wr(input logic [15:0] addr, input logic [15:0] data, output logic [15:0] sent);
    sent = (addr == MCB_OFS_TADDR) ? data : (data & MCB_MODE_MASK);
    if (addr == MCB_OFS_TADDR && sent[10:0] == READ_TEST_ADDR) begin
      sent[0] = ~sent[0];
    end
    @(posedge mclk);
    reg_addr  <= addr;
    reg_wdata <= sent;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    // released lines show no stale value
    reg_wdata <= ~sent;
    reg_addr  <= ~addr;
  endtask

  // one read pulse; answer taken while the valid pulse stands
  task automatic rd(input logic [15:0] addr, output logic [15:0] data, output logic ok);
    @(posedge mclk);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= ~addr;
    @(negedge mclk);
    data = reg_rdata;
    ok   = reg_rvalid;
  endtask
endmodule

// file: verification/mode_control_set_clear_bank_bench.sv
// mode_control_set_clear_bank_bench: self-checking bench for the mode bank.
// assumes the bank's default parameters and a 50 MHz clock.
`timescale 1ns/1ns
module mode_control_set_clear_bank_bench;
  import mcb_pkg::*;
  logic        MCLK, RSTN, REG_WR, REG_RD, REG_RVALID;
  logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA;
  logic        CONVERT_EN, DATA_RESET, MEM_TEST_EN, STORE_FROM_TEST, COMMON_STOP, EMPTY_EVENT_WRITE;
  logic [10:0] TEST_WRITE_ADDR;
  logic        SLIDE_STEP, SLIDE_SUB_BYPASS, SAMPLE_STB, SAMPLE_OVERFLOW, SAMPLE_VALID, SAMPLE_ACCEPT;
  logic [7:0]  SLIDE_CONST, SLIDE_DAC, SAMPLE_THRESHOLD;
  logic [11:0] SAMPLE_VALUE;
  logic        TRIGGER, TRIGGER_ACCEPTED, EVENT_COUNT_INC, BUFFER_READ, MANUAL_ADVANCE, READ_POINTER_ADVANCE;
  int          n_errors, tests_run, cycles;
  integer      seed;
  logic [15:0] mode, rdat, sent;
  logic [7:0]  slide_exp;
  logic [63:0] rr;
  logic        rok;

  ////////////////////////////////////////////////////////////////////////////////
  mcb_mode_bank uut (
    .MCLK, .RSTN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .REG_RVALID,
    .CONVERT_EN, .DATA_RESET, .MEM_TEST_EN, .TEST_WRITE_ADDR, .STORE_FROM_TEST, .COMMON_STOP,
    .EMPTY_EVENT_WRITE, .SLIDE_STEP, .SLIDE_CONST, .SLIDE_DAC, .SLIDE_SUB_BYPASS, .SAMPLE_STB,
    .SAMPLE_VALUE, .SAMPLE_THRESHOLD, .SAMPLE_OVERFLOW, .SAMPLE_VALID, .SAMPLE_ACCEPT, .TRIGGER,
    .TRIGGER_ACCEPTED, .EVENT_COUNT_INC, .BUFFER_READ, .MANUAL_ADVANCE, .READ_POINTER_ADVANCE
  );
  mcb_host_model host (
    .mclk(MCLK), .reg_addr(REG_ADDR), .reg_wdata(REG_WDATA), .reg_wr(REG_WR), .reg_rd(REG_RD),
    .reg_rdata(REG_RDATA), .reg_rvalid(REG_RVALID)
  );

  // 20 ns clock
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  // hang guard, well above the expected run length
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_errors = n_errors + 1;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // mode-driven levels in port order
  function automatic logic [6:0] ctl_exp(input logic [15:0] m);
    return {~m[MCB_B_OFFLINE], m[MCB_B_DATA_RST], m[0], m[6], m[MCB_B_STOP_MODE], m[MCB_B_EMPTY_WR],
            m[MCB_B_SLIDE_SUB]};
  endfunction

  // storage decision for one sample
  function automatic logic acc_exp(input logic [15:0] m, input logic [11:0] v, input logic [7:0] t,
                                   input logic o, input logic ok);
    int lim;
    lim = m[MCB_B_THR_RES] ? t * 2 : t * 16;
    return (m[MCB_B_OVR_DIS] | ~o) & (m[MCB_B_ZS_DIS] | (int'(v) >= lim))
           & (~m[MCB_B_STOP_MODE] | m[MCB_B_VALID_DIS] | ok);
  endfunction

  // set or clear, then read back and check the derived levels
  task automatic put(input logic set, input logic [15:0] d);
    host.wr(set ? MCB_OFS_SET : MCB_OFS_CLEAR, d, sent);
    mode = set ? (mode | sent) : (mode & ~sent);
    host.rd(MCB_OFS_SET, rdat, rok);
    check({rok, rdat}, {1'b1, mode});
    check({CONVERT_EN, DATA_RESET, MEM_TEST_EN, STORE_FROM_TEST, COMMON_STOP, EMPTY_EVENT_WRITE,
           SLIDE_SUB_BYPASS}, ctl_exp(mode));
  endtask

  // one cycle of random samples, triggers and reads; strobes dropped after one edge
  task automatic pulse();
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    @(posedge MCLK);
    {SAMPLE_VALUE, SAMPLE_THRESHOLD, SAMPLE_OVERFLOW, SAMPLE_VALID} <= r[21:0];
    {TRIGGER, TRIGGER_ACCEPTED, BUFFER_READ, MANUAL_ADVANCE, SLIDE_STEP} <= r[26:22];
    SLIDE_CONST <= r[34:27];
    SAMPLE_STB <= 1'b1;
    @(posedge MCLK);
    {SAMPLE_VALUE, SAMPLE_THRESHOLD, SAMPLE_OVERFLOW, SAMPLE_VALID} <= ~r[21:0];
    {TRIGGER, TRIGGER_ACCEPTED, BUFFER_READ, MANUAL_ADVANCE, SLIDE_STEP, SAMPLE_STB} <= '0;
    @(negedge MCLK);
    check(SAMPLE_ACCEPT, acc_exp(mode, r[21:10], r[9:2], r[1], r[0]));
    check({EVENT_COUNT_INC, READ_POINTER_ADVANCE},
          {r[26] & (mode[14] | r[25]), mode[11] ? r[24] : r[23]});
    // running slide counter: the output shows the count before this step
    if (mode[MCB_B_SLIDE_EN]) begin
      check(SLIDE_DAC, slide_exp);
      slide_exp = slide_exp + {7'h00, r[22]};
    end else begin
      check(SLIDE_DAC, r[34:27]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: reset, corners, then random traffic
  initial begin
    {RSTN, SLIDE_STEP, SLIDE_CONST, SAMPLE_STB, SAMPLE_VALUE, SAMPLE_THRESHOLD} = '0;
    {SAMPLE_OVERFLOW, SAMPLE_VALID, TRIGGER, TRIGGER_ACCEPTED, BUFFER_READ, MANUAL_ADVANCE} = '0;
    {n_errors, tests_run, cycles} = '0;
    slide_exp = '0;
    seed = 32'hB6EEC333;
    mode = 16'h4880;
    repeat (12) @(posedge MCLK);
    RSTN <= 1'b1;
    put(1'b1, 16'h0000);
    // write-only and unmapped places answer zero
    host.rd(MCB_OFS_CLEAR, rdat, rok);
    check({rok, rdat}, 17'h10000);
    host.rd(MCB_OFS_TADDR, rdat, rok);
    check({rok, rdat}, 17'h10000);
    host.rd(16'h1038, rdat, rok);
    check({rok, rdat}, 17'h10000);
    // data reset held until cleared, then all bits up and down
    put(1'b1, 16'h0004);
    pulse();
    put(1'b0, 16'h0004);
    put(1'b1, 16'hFFFF);
    repeat (3) pulse();
    put(1'b0, 16'hFFFF);
    repeat (3) pulse();
    // test write address
    repeat (4) begin
      rr = {$random(seed), $random(seed)};
      host.wr(MCB_OFS_TADDR, rr[15:0], sent);
      repeat (2) @(posedge MCLK);
      @(negedge MCLK);
      check(TEST_WRITE_ADDR, sent[10:0]);
    end
    // mid-run reset returns every mode bit and the test address to defaults
    @(posedge MCLK);
    RSTN <= 1'b0;
    repeat (3) @(posedge MCLK);
    RSTN <= 1'b1;
    mode = MCB_MODE_RESET;
    slide_exp = '0;
    check(TEST_WRITE_ADDR, 11'h000);
    put(1'b1, MCB_ZERO16);
    // random set and clear traffic
    repeat (60) begin
      rr = {$random(seed), $random(seed)};
      put(rr[16], rr[15:0]);
      repeat (4) pulse();
    end
    finish_test();
  end
endmodule
